// ===== core/flash_prot_defs.svh
// Constants for the flash rewrite protection block
// What this block does
// R1: Program and erase start only on commands
// R2: One enable bit guards the two lowest blocks
// R3: Enable clear ignores commands to those blocks
// R4: Erase works on one whole block only
// R5: Software never reprograms a word before erasing; this block does not check it
// R6: Both strap pins high at reset selects boot
// R7: Every rewrite of the boot area is refused
// R8: Release nonzero and level not 11 blocks parallel
// R9: Release 00 lifts the parallel protection
// R10: Parallel port cannot change the release field while protected
// R11: Level field counts only when release is nonzero
// R12: Protect bits clear only; block 0 erase sets ones
// R13: Serial mode compares received and stored ID
// R14: ID mismatch refuses all serial commands unless the stored ID is blank
// R15: Stored ID bytes read from fixed high addresses
// R16: Serial link is clock synchronous or UART
// R17: In place mode spares the routine's own block
// R18: Protect byte write is AND with stored value
`ifndef FLASH_PROT_DEFS_SVH
`define FLASH_PROT_DEFS_SVH

// ----------------------------------------
// Register word indices (byte address / 4)
// ----------------------------------------
`define REG_CTRL 6'h00
`define REG_CMD 6'h01
`define REG_ADDR 6'h02
`define REG_WDATA 6'h03
`define REG_STATUS 6'h04
`define REG_PROTECT 6'h05
`define REG_IDRX_LO 6'h06
`define REG_IDRX_HI 6'h07
`define REG_IDCHK 6'h08

// ----------------------------------------
// Control and status fields
// ----------------------------------------
`define CTRL_LBWE 0
`define CTRL_INPLACE 1
`define CTRL_UART 2
`define CTRL_EXEC_LO 4
`define CTRL_EXEC_HI 5
`define STAT_BUSY 0
`define STAT_REFUSED 1
`define STAT_BOOT 2
`define STAT_IDOK 3
`define STAT_LOCKED 4
`define STAT_PARBLK 5

// ----------------------------------------
// Flash map and protect byte
// ----------------------------------------
`define BLK0_BASE 20'hfe000
`define BLK1_BASE 20'hfc000
`define BLK2_BASE 20'hf8000
`define BOOT_BASE 20'h0f000
`define BOOT_TOP 20'h0ffff
`define PB_WORD_ADDR 20'hffffe
`define PB_ERASED 8'hff
`define PB_LEVEL_ON 2'h3
`define PB_RELEASE_OFF 2'h0
`define ID_BLANK 8'hff
`define ID_COUNT 3'h5
`define ID_ADDR0 20'hfffdf
`define ID_ADDR1 20'hfffe3
`define ID_ADDR2 20'hfffeb
`define ID_ADDR3 20'hffff3
`define ID_ADDR4 20'hffffb

`endif

// ===== core/flash_prot_pkg.sv
// Types shared by the flash rewrite protection block
package flash_prot_pkg;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_PROGRAM,
        OP_ERASE,
        OP_READ
    } flash_op_t;

    typedef struct packed {
        flash_op_t op;
        logic [19:0] addr;
        logic [15:0] data;
    } flash_req_t;

    typedef enum {
        ST_IDLE,
        ST_OP,
        ST_IDREAD
    } ctl_state_t;

endpackage

// ===== core/flash_rewrite_protection.sv
// Flash rewrite protection controller with AHB-Lite registers
//
// Chosen here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "flash_prot_defs.svh"

module flash_rewrite_protection (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [31:0] hrdata_out,
    // Flash array port
    output flash_prot_pkg::flash_req_t flash_req_out,
    output logic flash_valid_out,
    input wire logic flash_done_in,
    input wire logic [7:0] flash_rdata_in,
    // Pins
    input wire logic boot_select_pin_in,
    input wire logic boot_strap_port_pin_in,
    input wire logic serial_mode_in,
    input wire logic parallel_mode_in,
    input wire logic par_pb_we_in,
    input wire logic [7:0] par_pb_data_in,
    // Mode and protection status
    output logic boot_mode_out,
    output logic parallel_block_out,
    output logic serial_locked_out,
    output logic serial_uart_out,
    output logic in_place_rewrite_mode_out
);
    import flash_prot_pkg::*;

    // Block index of a flash address, used for several checks
    function automatic logic [2:0] block_of(input logic [19:0] a);
        if (a >= `BLK0_BASE) begin
            block_of = 3'h0;
        end else if (a >= `BLK1_BASE) begin
            block_of = 3'h1;
        end else if (a >= `BLK2_BASE) begin
            block_of = 3'h2;
        end else begin
            block_of = 3'h3;
        end
    endfunction

    // Stored ID byte locations, lowest first
    function automatic logic [19:0] id_addr(input logic [2:0] i);
        case (i)
            3'h0: id_addr = `ID_ADDR0;
            3'h1: id_addr = `ID_ADDR1;
            3'h2: id_addr = `ID_ADDR2;
            3'h3: id_addr = `ID_ADDR3;
            default: id_addr = `ID_ADDR4;
        endcase
    endfunction

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [12:0] sync1_r;
    logic [12:0] sync2_r;
    logic par_we_prev_r;

    // Two stages before anything looks at a pin; kept out of reset so
    // the straps are settled while reset is held and boot can be caught
    always_ff @(posedge clk_in) begin
        sync1_r <= {par_pb_data_in, par_pb_we_in, parallel_mode_in,
                    serial_mode_in, boot_strap_port_pin_in,
                    boot_select_pin_in};
        sync2_r <= sync1_r;
        // Tracks the pin through reset, so no false edge follows it
        par_we_prev_r <= sync2_r[4];
    end

    logic strap_both;
    logic ser_mode;
    logic par_mode;
    logic par_we_pulse;
    logic [7:0] par_data;
    assign strap_both = sync2_r[0] & sync2_r[1];
    assign ser_mode = sync2_r[2];
    assign par_mode = sync2_r[3];
    assign par_we_pulse = sync2_r[4] & ~par_we_prev_r;
    assign par_data = sync2_r[12:5];

    // ----------------------------------------
    // AHB-Lite slave
    // ----------------------------------------
    logic dp_we_r, dp_we_nxt;
    logic [5:0] dp_idx_r, dp_idx_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic [31:0] rd_word;
    logic take;
    logic wr;

    assign take = hsel_in & htrans_in[1] & hready_in;
    assign wr = dp_we_r;
    assign hreadyout_out = 1'b1;   // Zero wait states, never stalls
    assign hresp_out = 1'b0;       // Always OKAY
    assign hrdata_out = hrdata_r;

    // Address phase capture; read data registered for the data phase
    always_comb begin
        dp_we_nxt = take & hwrite_in;
        dp_idx_nxt = haddr_in[7:2];
        hrdata_nxt = hrdata_r;
        if (take & ~hwrite_in) begin
            hrdata_nxt = rd_word;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            dp_we_r <= 1'b0;
            dp_idx_r <= 6'h00;
            hrdata_r <= 32'h0000_0000;
        end else begin
            dp_we_r <= dp_we_nxt;
            dp_idx_r <= dp_idx_nxt;
            hrdata_r <= hrdata_nxt;
        end
    end

    // ----------------------------------------
    // Core state
    // ----------------------------------------
    ctl_state_t state_r, state_nxt;
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [19:0] addr_r, addr_nxt;
    logic [15:0] wdata_r, wdata_nxt;
    logic [7:0] pb_r, pb_nxt;
    logic [39:0] idrx_r, idrx_nxt;
    logic [2:0] idx_r, idx_nxt;
    logic match_r, match_nxt;
    logic blank_r, blank_nxt;
    logic id_ok_r, id_ok_nxt;
    logic refused_r, refused_nxt;
    logic boot_r, boot_nxt;
    flash_req_t req_r, req_nxt;

    logic [2:0] tgt_blk;
    logic in_boot;
    logic prot_active;
    logic cmd_refuse;
    logic [7:0] rx_byte;
    flash_op_t cmd_op;
    logic is_cmd;

    assign tgt_blk = block_of(addr_r);
    assign in_boot = (addr_r >= `BOOT_BASE) && (addr_r <= `BOOT_TOP);
    // Level field is only looked at while release is nonzero
    assign prot_active = (pb_r[1:0] != `PB_RELEASE_OFF) &&
                         (pb_r[3:2] != `PB_LEVEL_ON); // R8 R9 R11
    assign is_cmd = wr && (dp_idx_r == `REG_CMD);
    assign cmd_op = flash_op_t'(hwdata_in[1:0]);
    assign rx_byte = idrx_r[{idx_r, 3'b000} +: 8];

    // Any one of these stops a command before it reaches the array
    always_comb begin
        cmd_refuse = 1'b0;
        if (state_r != ST_IDLE) begin
            cmd_refuse = 1'b1;
        end
        if (cmd_op == OP_NONE || cmd_op == OP_READ) begin
            cmd_refuse = 1'b1;
        end
        if (in_boot) begin
            cmd_refuse = 1'b1; // R7
        end
        if (tgt_blk < 3'h2 && !ctrl_r[`CTRL_LBWE]) begin
            cmd_refuse = 1'b1; // R2 R3
        end
        if (ctrl_r[`CTRL_INPLACE] &&
            tgt_blk[1:0] == ctrl_r[`CTRL_EXEC_HI:`CTRL_EXEC_LO]) begin
            cmd_refuse = 1'b1; // R17
        end
        if (ser_mode && !id_ok_r) begin
            cmd_refuse = 1'b1; // R14
        end
        if (par_mode && prot_active) begin
            cmd_refuse = 1'b1; // R8
        end
    end

    // Register read mux; unmapped words read zero
    always_comb begin
        case (haddr_in[7:2])
            `REG_CTRL: rd_word = {24'h000000, ctrl_r};
            `REG_ADDR: rd_word = {12'h000, addr_r};
            `REG_WDATA: rd_word = {16'h0000, wdata_r};
            `REG_STATUS: rd_word = {26'h0000000, parallel_block_out,
                                    serial_locked_out, id_ok_r, boot_r,
                                    refused_r, state_r != ST_IDLE};
            `REG_PROTECT: rd_word = {24'h000000, pb_r};
            `REG_IDRX_LO: rd_word = idrx_r[31:0];
            `REG_IDRX_HI: rd_word = {24'h000000, idrx_r[39:32]};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // Next state of control registers, sequencer and flash request
    always_comb begin
        state_nxt = state_r;
        ctrl_nxt = ctrl_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        pb_nxt = pb_r;
        idrx_nxt = idrx_r;
        idx_nxt = idx_r;
        match_nxt = match_r;
        blank_nxt = blank_r;
        id_ok_nxt = id_ok_r;
        refused_nxt = refused_r;
        boot_nxt = boot_r;
        req_nxt = req_r;
        // Strap is caught on every reset cycle, frozen after release
        if (rst_in) begin
            boot_nxt = strap_both; // R6
        end
        if (wr) begin
            case (dp_idx_r)
                `REG_CTRL: ctrl_nxt = hwdata_in[7:0];
                `REG_ADDR: addr_nxt = hwdata_in[19:0];
                `REG_WDATA: wdata_nxt = hwdata_in[15:0];
                `REG_STATUS: begin
                    if (hwdata_in[`STAT_REFUSED]) begin
                        refused_nxt = 1'b0;
                    end
                end
                `REG_PROTECT: pb_nxt = pb_r & hwdata_in[7:0]; // R12 R18
                `REG_IDRX_LO: idrx_nxt[31:0] = hwdata_in;
                `REG_IDRX_HI: idrx_nxt[39:32] = hwdata_in[7:0];
                default: ;
            endcase
        end
        // Parallel port writes keep the release field while protected
        if (par_mode && par_we_pulse) begin
            pb_nxt = pb_nxt & par_data; // R12
            if (prot_active) begin
                pb_nxt[1:0] = pb_r[1:0]; // R10
            end
        end
        case (state_r)
            ST_IDLE: begin
                if (is_cmd) begin
                    if (cmd_refuse) begin
                        refused_nxt = 1'b1;
                    end else begin
                        state_nxt = ST_OP; // R1
                        req_nxt.op = cmd_op;
                        req_nxt.addr = addr_r;
                        req_nxt.data = wdata_r;
                        if (cmd_op == OP_ERASE) begin
                            req_nxt.addr = {addr_r[19:13], 13'h0000}; // R4
                        end
                    end
                end else if (wr && dp_idx_r == `REG_IDCHK) begin
                    state_nxt = ST_IDREAD; // R13
                    idx_nxt = 3'h0;
                    match_nxt = 1'b1;
                    blank_nxt = 1'b1;
                    id_ok_nxt = 1'b0;
                    req_nxt.op = OP_READ;
                    req_nxt.addr = id_addr(3'h0); // R15
                end
            end
            ST_OP: begin
                if (flash_done_in) begin
                    state_nxt = ST_IDLE;
                    req_nxt.op = OP_NONE;
                    // Mirror the array: erase of block 0 restores ones
                    if (req_r.op == OP_ERASE &&
                        block_of(req_r.addr) == 3'h0) begin
                        pb_nxt = `PB_ERASED; // R12
                    end
                    if (req_r.op == OP_PROGRAM &&
                        req_r.addr == `PB_WORD_ADDR) begin
                        pb_nxt = pb_nxt & req_r.data[15:8]; // R18
                    end
                end
            end
            ST_IDREAD: begin
                if (flash_done_in) begin
                    if (flash_rdata_in != rx_byte) begin
                        match_nxt = 1'b0; // R13
                    end
                    if (flash_rdata_in != `ID_BLANK) begin
                        blank_nxt = 1'b0;
                    end
                    if (idx_r == `ID_COUNT - 3'h1) begin
                        state_nxt = ST_IDLE;
                        req_nxt.op = OP_NONE;
                        id_ok_nxt = (match_nxt | blank_nxt); // R14
                    end else begin
                        idx_nxt = idx_r + 3'h1;
                        req_nxt.addr = id_addr(idx_r + 3'h1); // R15
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                req_nxt.op = OP_NONE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_r <= ST_IDLE;
            ctrl_r <= 8'h00;
            addr_r <= 20'h00000;
            wdata_r <= 16'h0000;
            pb_r <= `PB_ERASED;
            idrx_r <= 40'h00_0000_0000;
            idx_r <= 3'h0;
            match_r <= 1'b0;
            blank_r <= 1'b0;
            id_ok_r <= 1'b0;
            refused_r <= 1'b0;
            req_r <= '0;
        end else begin
            state_r <= state_nxt;
            ctrl_r <= ctrl_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            pb_r <= pb_nxt;
            idrx_r <= idrx_nxt;
            idx_r <= idx_nxt;
            match_r <= match_nxt;
            blank_r <= blank_nxt;
            id_ok_r <= id_ok_nxt;
            refused_r <= refused_nxt;
            req_r <= req_nxt;
        end
    end

    // Boot flag is not reset-cleared: it loads from the strap
    always_ff @(posedge clk_in) begin
        boot_r <= boot_nxt;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign flash_req_out = req_r;
    assign flash_valid_out = (state_r != ST_IDLE);
    assign boot_mode_out = boot_r;
    assign parallel_block_out = par_mode & prot_active; // R8 R9
    assign serial_locked_out = ser_mode & ~id_ok_r; // R14
    assign serial_uart_out = ctrl_r[`CTRL_UART]; // R16
    assign in_place_rewrite_mode_out = ctrl_r[`CTRL_INPLACE]; // R17

endmodule
`default_nettype wire

// ===== tb/flash_prot_monitor.sv
// Port checker for the flash rewrite protection block
`timescale 1ns/1ns
`default_nettype none
`include "flash_prot_defs.svh"
module flash_prot_monitor
    import flash_prot_pkg::*;
(
    // Clock, reset and bus
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    // Flash port and status pins
    input wire flash_prot_pkg::flash_req_t flash_req_out,
    input wire logic flash_valid_out,
    input wire logic flash_done_in,
    input wire logic boot_mode_out,
    input wire logic parallel_block_out,
    input wire logic serial_locked_out,
    input wire logic serial_uart_out,
    input wire logic in_place_rewrite_mode_out
);
    logic ap_wr_r, lbwe_r, inpl_r, uart_r, pe;
    logic [5:0] ap_idx_r;
    logic [19:0] fa;
    assign fa = flash_req_out.addr;
    assign pe = flash_valid_out &&
                flash_req_out.op inside {OP_PROGRAM, OP_ERASE};
    // Shadow of the control word, rebuilt from observed bus writes
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ap_wr_r <= 1'b0;
            ap_idx_r <= 6'h00;
            lbwe_r <= 1'b0;
            inpl_r <= 1'b0;
            uart_r <= 1'b0;
        end else begin
            ap_wr_r <= hsel_in && htrans_in[1] && hready_in && hwrite_in;
            ap_idx_r <= haddr_in[7:2];
            if (ap_wr_r && ap_idx_r == `REG_CTRL) begin
                lbwe_r <= hwdata_in[`CTRL_LBWE];
                inpl_r <= hwdata_in[`CTRL_INPLACE];
                uart_r <= hwdata_in[`CTRL_UART];
            end
        end
    end
    // ----
    // Properties
    // ----
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    AST_CMD_CAUSE: assert property ($rose(flash_valid_out) && pe
        |-> $past(ap_wr_r && ap_idx_r == `REG_CMD))
        else $error("op without cmd");
    AST_REQ_STANDS: assert property (flash_valid_out && !flash_done_in
        |=> flash_valid_out && $stable(flash_req_out))
        else $error("req moved");
    AST_DONE_ENDS: assert property (pe && flash_done_in
        |=> !flash_valid_out) else $error("valid held after done");
    AST_LOW_GUARD: assert property (pe && fa >= `BLK1_BASE |-> lbwe_r)
        else $error("low block op while disabled");
    AST_ERASE_WHOLE: assert property (pe && flash_req_out.op == OP_ERASE
        |-> fa[12:0] == 13'h0) else $error("erase not block aligned");
    AST_BOOT_SAFE: assert property (pe
        |-> !(fa >= `BOOT_BASE && fa <= `BOOT_TOP))
        else $error("boot rewrite");
    AST_LOCK_REFUSE: assert property ($rose(flash_valid_out) && pe
        |-> !$past(parallel_block_out) && !$past(serial_locked_out))
        else $error("op while locked");
    AST_BOOT_HOLD: assert property (!$past(rst_in)
        |-> $stable(boot_mode_out)) else $error("boot mode moved");
    AST_UART_BIT: assert property (serial_uart_out == uart_r)
        else $error("link form wrong");
    AST_INPLACE_BIT: assert property (
        in_place_rewrite_mode_out == inpl_r) else $error("rewrite mode wrong");
endmodule
`default_nettype wire

// ===== tb/flash_array_model.sv
// Behavioural flash array facing the protection block
`timescale 1ns/1ns
`default_nettype none
`include "flash_prot_defs.svh"
module flash_array_model
    import flash_prot_pkg::*;
#(
    // Test ID bytes, byte0 lowest; values are arbitrary
    parameter logic [39:0] ID_BYTES = 40'h5e_c4_37_a9_1b
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Access from the block
    input wire flash_prot_pkg::flash_req_t req_in,
    input wire logic valid_in,
    input wire logic [3:0] delay_in,
    input wire logic blank_in,
    output logic done_out,
    output logic [7:0] rdata_out
);
    logic [3:0] cnt_r;
    // Stored byte at a fixed high ID address, or the erased level
    function automatic logic [7:0] id_at(input logic [19:0] a);
        if (blank_in) return `ID_BLANK;
        case (a)
            `ID_ADDR0: return ID_BYTES[7:0];
            `ID_ADDR1: return ID_BYTES[15:8];
            `ID_ADDR2: return ID_BYTES[23:16];
            `ID_ADDR3: return ID_BYTES[31:24];
            `ID_ADDR4: return ID_BYTES[39:32];
            default: return 8'h00;
        endcase
    endfunction
    // Wait the latency, then pulse done; data toggles every cycle except when done loads it
    always_ff @(posedge clk_in) begin
        rdata_out <= rst_in ? 8'h00 : ~rdata_out;
        if (rst_in || !valid_in || done_out) begin
            cnt_r <= 4'h0;
            done_out <= 1'b0;
        end else if (cnt_r == delay_in) begin
            cnt_r <= 4'h0;
            done_out <= 1'b1;
            rdata_out <= id_at(req_in.addr);
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Register-level testbench for the flash rewrite protection block
`timescale 1ns/1ns
`default_nettype none
`include "flash_prot_defs.svh"
module tb_top;
    import flash_prot_pkg::*;
    localparam logic [39:0] ID = 40'h5e_c4_37_a9_1b;
    logic clk_in = 1'b0, rst_in = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
    logic [1:0] htrans = 2'h0;
    logic hready, hresp, fvalid, fdone, bport = 1'b1, smode = 1'b0;
    logic pmode = 1'b0, pwe = 1'b0, blank = 1'b0, bsel = 1'b1;
    logic [7:0] pdata = 8'h00, frd;
    logic [3:0] dly = 4'h0;
    logic boot, pblk, slock, suart, inpl;
    flash_req_t req;
    int fail_count = 0, n_compared = 0;
    // Free-running 50 MHz clock
    always #10 clk_in = ~clk_in;
    flash_rewrite_protection uut (
        .clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
        .hwdata_in(hwdata), .hready_in(hready), .hreadyout_out(hready),
        .hresp_out(hresp), .hrdata_out(hrdata), .flash_req_out(req),
        .flash_valid_out(fvalid), .flash_done_in(fdone),
        .flash_rdata_in(frd), .boot_select_pin_in(bsel),
        .boot_strap_port_pin_in(bport), .serial_mode_in(smode),
        .parallel_mode_in(pmode), .par_pb_we_in(pwe),
        .par_pb_data_in(pdata), .boot_mode_out(boot),
        .parallel_block_out(pblk), .serial_locked_out(slock),
        .serial_uart_out(suart), .in_place_rewrite_mode_out(inpl));
    flash_array_model #(.ID_BYTES(ID)) fam (
        .clk_in(clk_in), .rst_in(rst_in), .req_in(req), .valid_in(fvalid),
        .delay_in(dly), .blank_in(blank), .done_out(fdone),
        .rdata_out(frd));
    // ----
    // Bus and check tasks
    // ----
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One single AHB transfer; read data lands in rd
    task automatic xfer(input logic [5:0] idx, input logic w,
            input logic [31:0] wd);
        @(posedge clk_in);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, idx, 2'b00};
        @(posedge clk_in);
        // Only the watchdog ends a wait for the slave
        while (hready !== 1'b1) @(posedge clk_in);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clk_in);
        while (hready !== 1'b1) @(posedge clk_in);
        rd = hrdata;
        #1;
    endtask
    task automatic wr(input logic [5:0] idx, input logic [31:0] wd);
        xfer(idx, 1'b1, wd);
    endtask
    task automatic rdm(input logic [5:0] idx, input logic [31:0] m);
        xfer(idx, 1'b0, 32'h0);
        rd = rd & m;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // Bounded wait for the flash port to go quiet
    task automatic idle;
        for (int t = 0; t < 200 && fvalid !== 1'b0; t++) settle(1);
    endtask
    // Issue a command and expect it to start or be refused
    task automatic cmd(input logic [1:0] op, input logic [19:0] a,
            input logic go, input logic [19:0] ea);
        wr(`REG_ADDR, {12'h0, a});
        wr(`REG_WDATA, 32'hc3a5);
        wr(`REG_CMD, {30'h0, op});
        chk("flash_valid", go, fvalid);
        if (go) begin
            chk("flash_op", op, req.op);
            chk("flash_addr", ea, req.addr);
            chk("flash_data", 32'hc3a5, req.data);
        end
        idle;
        rdm(`REG_STATUS, 32'h2);
        chk("refused", {30'h0, ~go, 1'b0}, rd);
        wr(`REG_STATUS, 32'h2);
    endtask
    task automatic do_reset;
        @(posedge clk_in) rst_in <= 1'b1;
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
    endtask
    task tally_and_finish;
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Watchdog: the tests need a few hundred cycles
    initial begin
        #400000;
        fail_count++;
        $display("watchdog expired");
        tally_and_finish;
    end
    // ----
    // Test sequence
    // ----
    initial begin
        do_reset;
        settle(1);
        chk("boot_mode", 1, boot);
        chk("hresp_okay", 0, hresp);
        rdm(`REG_STATUS, 32'h4);
        chk("status_boot", 32'h4, rd);
        rdm(`REG_PROTECT, 32'hff);
        chk("protect_reset", 32'hff, rd);
        wr(6'h3f, 32'hffffffff);
        rdm(6'h3f, 32'hffffffff);
        chk("unmapped", 32'h0, rd);
        $display("reset test done");
        cmd(2'h1, 20'hf8010, 1'b1, 20'hf8010);
        @(posedge clk_in) dly <= 4'h7;
        cmd(2'h2, 20'hf9234, 1'b1, 20'hf8000);
        cmd(2'h1, 20'hfe000, 1'b0, 20'h0);
        cmd(2'h2, 20'hfc100, 1'b0, 20'h0);
        cmd(2'h3, 20'hf8000, 1'b0, 20'h0);
        wr(`REG_CTRL, 32'h1);
        cmd(2'h1, 20'hfe002, 1'b1, 20'hfe002);
        cmd(2'h2, 20'h0f100, 1'b0, 20'h0);
        wr(`REG_CTRL, 32'h27);
        chk("in_place", 1, inpl);
        chk("uart", 1, suart);
        cmd(2'h1, 20'hf8020, 1'b0, 20'h0);
        cmd(2'h1, 20'hfe004, 1'b1, 20'hfe004);
        wr(`REG_CTRL, 32'h1);
        chk("uart_off", 0, suart);
        $display("command test done");
        @(posedge clk_in) pmode <= 1'b1;
        wr(`REG_PROTECT, 32'hfd);
        settle(3);
        chk("level_on", 0, pblk);
        wr(`REG_PROTECT, 32'hf1);
        settle(3);
        chk("blocked", 1, pblk);
        wr(`REG_PROTECT, 32'hff);
        rdm(`REG_PROTECT, 32'hff);
        chk("clear_only", 32'hf1, rd);
        cmd(2'h1, 20'hf8030, 1'b0, 20'h0);
        @(posedge clk_in) pwe <= 1'b1;
        settle(4);
        @(posedge clk_in) pwe <= 1'b0;
        settle(4);
        rdm(`REG_PROTECT, 32'hf);
        chk("par_release", 32'h1, rd);
        wr(`REG_PROTECT, 32'hf0);
        settle(3);
        chk("released", 0, pblk);
        cmd(2'h2, 20'hfe010, 1'b1, 20'hfe000);
        rdm(`REG_PROTECT, 32'hff);
        chk("protect_erased", 32'hff, rd);
        @(posedge clk_in) pmode <= 1'b0;
        $display("protect test done");
        @(posedge clk_in) smode <= 1'b1;
        wr(`REG_IDRX_LO, ID[31:0]);
        wr(`REG_IDRX_HI, {24'h0, ID[39:32]});
        wr(`REG_IDCHK, 32'h1);
        idle;
        rdm(`REG_STATUS, 32'h18);
        chk("id_match", 32'h8, rd);
        wr(`REG_IDRX_HI, 32'h0);
        wr(`REG_IDCHK, 32'h1);
        idle;
        chk("id_locked", 1, slock);
        cmd(2'h1, 20'hf8040, 1'b0, 20'h0);
        @(posedge clk_in) blank <= 1'b1;
        wr(`REG_IDCHK, 32'h1);
        idle;
        chk("id_blank", 0, slock);
        $display("id test done");
        @(posedge clk_in) bsel <= 1'b0;
        do_reset;
        settle(1);
        chk("select_low_boot", 0, boot);
        @(posedge clk_in) bsel <= 1'b1;
        do_reset;
        settle(1);
        chk("both_high_boot", 1, boot);
        @(posedge clk_in) bport <= 1'b0;
        do_reset;
        settle(1);
        chk("user_boot", 0, boot);
        $display("boot test done");
        tally_and_finish;
    end
endmodule
bind flash_rewrite_protection flash_prot_monitor mon (
    .clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
    .hwdata_in(hwdata_in), .hready_in(hready_in),
    .flash_req_out(flash_req_out), .flash_valid_out(flash_valid_out),
    .flash_done_in(flash_done_in), .boot_mode_out(boot_mode_out),
    .parallel_block_out(parallel_block_out),
    .serial_locked_out(serial_locked_out),
    .serial_uart_out(serial_uart_out),
    .in_place_rewrite_mode_out(in_place_rewrite_mode_out));
`default_nettype wire
